// *** design/smt_pkg.sv ***
// Constants for the signal measurement mode engine
package measure_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DEF_CNT_W = 24;
	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_CNT = 8'h08;
	localparam logic [7:0] ADDR_LIMIT = 8'h0C;
	localparam logic [7:0] ADDR_CPW = 8'h10;
	localparam logic [7:0] ADDR_CPR = 8'h14;
	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	localparam int CTRL_GO = 0;
	localparam int CTRL_REPEAT = 1;
	localparam int CTRL_MODE_LSB = 4;
	localparam int CTRL_HALT = 8;
	localparam int CTRL_SIG_POL = 9;
	localparam int CTRL_WIN_POL = 10;
	localparam int CTRL_RST = 16;
	localparam int CTRL_CPWUP = 17;
	localparam int CTRL_CPRUP = 18;
	// ----------------------------------------
	// Status fields
	// ----------------------------------------
	localparam int STAT_PM = 0;
	localparam int STAT_PW = 1;
	localparam int STAT_PR = 2;
	localparam int STAT_RUN = 4;
	localparam int STAT_WIN = 5;
	localparam int STAT_SIG = 6;
	// ----------------------------------------
	// Mode codes
	// ----------------------------------------
	localparam logic [3:0] MODE_TIMER = 4'h0;
	localparam logic [3:0] MODE_GTIMER = 4'h1;
	localparam logic [3:0] MODE_PDUTY = 4'h2;
	localparam logic [3:0] MODE_HILO = 4'h3;
	localparam logic [3:0] MODE_WMEAS = 4'h4;
	localparam logic [3:0] MODE_GWMEAS = 4'h5;
	localparam logic [3:0] MODE_TOF = 4'h6;
	localparam logic [3:0] MODE_CAPT = 4'h7;
	localparam logic [3:0] MODE_CNTR = 4'h8;
	localparam logic [3:0] MODE_GCNTR = 4'h9;
	localparam logic [3:0] MODE_WCNTR = 4'hA;
	// ----------------------------------------
	// Reset and load values
	// ----------------------------------------
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [31:0] LIMIT_RST = 32'h00FFFFFF;
	localparam logic [31:0] LOAD_ONE = 32'h00000001;
endpackage

// *** design/signal_measurement_mode_engine.sv ***
// Mode engine of the signal measurement timer with a Wishbone register slave
// Operation
// - Single acquisition: on completion stop counting and clear run request.
// - Repeat acquisition: keep counting, new captures overwrite old ones.
// - Four-bit mode code picks one of eleven operations; codes above 1010 reserved.
// - Modes 0000-0111 use clock ticks; 1000-1010 count signal edges instead.
// - Timer mode: count every tick while running, no capture, inputs ignored.
// - Timer mode: counter equal to period limit resets counter, sets match flag.
// - Gated timer: count while signal active; signal fall captures pulse width.
// - Period/duty: signal fall captures width, signal rise captures period.
// - Period/duty: signal rise loads counter with one.
// - Period/duty single: completing signal rise clears run request.
// - High/low: start at rise; fall captures width, rise period, both reset.
// - Windowed measure: window rise captures period; repeat resets counter.
// - Gated windowed: count while signal high; later window rises capture, reset.
// - Time of flight: window rise starts; signal rise captures period, resets.
// - Time of flight: second window rise first captures width, then resets.
// - Capture: window rise to period, fall to width; captures never reset the counter.
// - Counter: count signal rises; window fall captures width.
// - Gated counter: count signal rises while window high; window fall captures.
// - Windowed counter: count from window rise; fall captures width, rise period.
// - Polarity bit one inverts the input: active low, falling edge.
// - Separate flags for width capture, period capture and period match.
// - Halt bit holds counter at limit on match, else counter returns to zero.
module signal_measurement_mode_engine
	import measure_pkg::*;
#(
	parameter int CNT_W = DEF_CNT_W
) (
	// Clock, reset, tick enable
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic ce,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Measured inputs
	input wire logic measured_signal_input,
	input wire logic window_input,
	// Status outputs
	output logic run_active,
	output logic period_match_flag,
	output logic width_capture_flag,
	output logic period_capture_flag
);
	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
		$error("CNT_W must lie in 2..32");
	end

	function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic go_q, repeat_q, halt_q, sig_pol_q, win_pol_q;
	logic [3:0] mode_q;
	logic [CNT_W-1:0] cnt_q, cnt_d, limit_q, cpw_q, cpr_q;
	logic pm_q, pw_q, pr_q, armed_q, armed_d;
	logic sig_s1_q, sig_s2_q, win_s1_q, win_s2_q, sig_prev_q, win_prev_q;
	logic ack_q;
	logic [31:0] dat_q;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire acc = cyc_i & stb_i;
	wire wr = acc & we_i & ack_q;
	wire wr_ctrl = wr & (adr_i == ADDR_CTRL);
	wire wr_stat = wr & (adr_i == ADDR_STAT);
	wire wr_cnt = wr & (adr_i == ADDR_CNT);
	wire wr_limit = wr & (adr_i == ADDR_LIMIT);
	wire [31:0] ctrl_rd = {21'h0, win_pol_q, sig_pol_q, halt_q, mode_q, 2'h0, repeat_q, go_q};
	wire [31:0] ctrl_new = wmerge(ctrl_rd, dat_i, sel_i);
	wire [31:0] stat_w1c = wmerge(32'h0, dat_i, sel_i);
	wire [31:0] cnt_new = wmerge(32'(cnt_q), dat_i, sel_i);
	wire [31:0] limit_new = wmerge(32'(limit_q), dat_i, sel_i);
	wire rst_req = wr_ctrl & ctrl_new[CTRL_RST];
	wire cpw_req = wr_ctrl & ctrl_new[CTRL_CPWUP];
	wire cpr_req = wr_ctrl & ctrl_new[CTRL_CPRUP];
	wire sw_cnt = wr_cnt | rst_req;

	// ----------------------------------------
	// Input conditioning
	// ----------------------------------------
	wire sig_lvl = sig_s2_q ^ sig_pol_q;
	wire win_lvl = win_s2_q ^ win_pol_q;
	wire sig_rise = sig_lvl & ~sig_prev_q;
	wire sig_fall = ~sig_lvl & sig_prev_q;
	wire win_rise = win_lvl & ~win_prev_q;
	wire win_fall = ~win_lvl & win_prev_q;
	wire [31:0] stat_rd = {25'h0, sig_lvl, win_lvl, go_q, 1'b0, pr_q, pw_q, pm_q};
	wire [31:0] rd_data = (adr_i == ADDR_CTRL) ? ctrl_rd :
		(adr_i == ADDR_STAT) ? stat_rd :
		(adr_i == ADDR_CNT) ? 32'(cnt_q) :
		(adr_i == ADDR_LIMIT) ? 32'(limit_q) :
		(adr_i == ADDR_CPW) ? 32'(cpw_q) :
		(adr_i == ADDR_CPR) ? 32'(cpr_q) : 32'h0;

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	logic inc, cap_pw, cap_pr, clr, load1, done;
	wire mode_rsv = mode_q > MODE_WCNTR;
	wire match_hit = go_q & ~mode_rsv & (cnt_q == limit_q);

	always_comb begin
		inc = 1'b0;
		cap_pw = 1'b0;
		cap_pr = 1'b0;
		clr = 1'b0;
		load1 = 1'b0;
		done = 1'b0;
		armed_d = armed_q;
		case (mode_q)
			MODE_TIMER: begin
				inc = 1'b1;
			end
			MODE_GTIMER: begin
				inc = sig_lvl;
				cap_pw = sig_fall;
				done = sig_fall;
			end
			MODE_PDUTY: begin
				inc = 1'b1;
				cap_pw = sig_fall;
				cap_pr = sig_rise;
				load1 = sig_rise;
				done = sig_rise & armed_q;
				armed_d = armed_q | sig_rise;
			end
			MODE_HILO: begin
				inc = armed_q;
				cap_pw = sig_fall & armed_q;
				cap_pr = sig_rise & armed_q;
				clr = sig_rise | (sig_fall & armed_q);
				done = sig_rise & armed_q;
				armed_d = armed_q | sig_rise;
			end
			MODE_WMEAS: begin
				inc = 1'b1;
				cap_pr = win_rise;
				clr = win_rise & repeat_q;
				done = win_rise;
			end
			MODE_GWMEAS: begin
				inc = armed_q & sig_lvl;
				cap_pr = win_rise & armed_q;
				clr = win_rise;
				done = win_rise & armed_q;
				armed_d = armed_q | win_rise;
			end
			MODE_TOF: begin
				inc = armed_q;
				cap_pr = sig_rise & armed_q & ~win_rise;
				cap_pw = win_rise & armed_q;
				clr = win_rise | cap_pr;
				done = cap_pr;
				armed_d = win_rise | (armed_q & ~cap_pr);
			end
			MODE_CAPT: begin
				inc = 1'b1;
				cap_pr = win_rise;
				cap_pw = win_fall;
				done = win_rise | win_fall;
			end
			MODE_CNTR: begin
				inc = sig_rise;
				cap_pw = win_fall;
				done = win_fall;
			end
			MODE_GCNTR: begin
				inc = sig_rise & win_lvl;
				cap_pw = win_fall;
				done = win_fall;
			end
			MODE_WCNTR: begin
				inc = sig_rise & armed_q;
				cap_pw = win_fall & armed_q;
				cap_pr = win_rise & armed_q;
				clr = win_rise;
				done = win_rise & armed_q;
				armed_d = armed_q | win_rise;
			end
			default: begin
				inc = 1'b0;
			end
		endcase
		if (!go_q) begin
			inc = 1'b0;
			cap_pw = 1'b0;
			cap_pr = 1'b0;
			clr = 1'b0;
			load1 = 1'b0;
			done = 1'b0;
			armed_d = 1'b0;
		end
	end

	// Counter priority: software, then load, reset, match, increment
	always_comb begin
		cnt_d = cnt_q;
		if (wr_cnt) begin
			cnt_d = cnt_new[CNT_W-1:0];
		end else if (rst_req) begin
			cnt_d = '0;
		end else if (load1) begin
			cnt_d = LOAD_ONE[CNT_W-1:0];
		end else if (clr) begin
			cnt_d = '0;
		end else if (match_hit) begin
			cnt_d = halt_q ? cnt_q : '0;
		end else if (inc) begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	wire set_pw = cap_pw | cpw_req;
	wire set_pr = cap_pr | cpr_req;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sig_s1_q <= 1'b0;
			sig_s2_q <= 1'b0;
			win_s1_q <= 1'b0;
			win_s2_q <= 1'b0;
			sig_prev_q <= 1'b0;
			win_prev_q <= 1'b0;
		end else if (ce) begin
			sig_s1_q <= measured_signal_input;
			sig_s2_q <= sig_s1_q;
			win_s1_q <= window_input;
			win_s2_q <= win_s1_q;
			sig_prev_q <= sig_lvl;
			win_prev_q <= win_lvl;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
		end else if (ce) begin
			ack_q <= acc & ~ack_q;
			dat_q <= rd_data;
		end
	end

	// Software set of the run request wins over a completion in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			go_q <= 1'b0;
			repeat_q <= 1'b0;
			mode_q <= MODE_RST;
			halt_q <= 1'b0;
			sig_pol_q <= 1'b0;
			win_pol_q <= 1'b0;
		end else if (ce) begin
			if (wr_ctrl) begin
				go_q <= ctrl_new[CTRL_GO];
				repeat_q <= ctrl_new[CTRL_REPEAT];
				mode_q <= ctrl_new[CTRL_MODE_LSB +: 4];
				halt_q <= ctrl_new[CTRL_HALT];
				sig_pol_q <= ctrl_new[CTRL_SIG_POL];
				win_pol_q <= ctrl_new[CTRL_WIN_POL];
			end else if (done && !repeat_q) begin
				go_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cnt_q <= '0;
			limit_q <= LIMIT_RST[CNT_W-1:0];
			cpw_q <= '0;
			cpr_q <= '0;
			armed_q <= 1'b0;
		end else if (ce) begin
			cnt_q <= cnt_d;
			armed_q <= armed_d;
			if (wr_limit) begin
				limit_q <= limit_new[CNT_W-1:0];
			end
			if (set_pw) begin
				cpw_q <= cnt_q;
			end
			if (set_pr) begin
				cpr_q <= cnt_q;
			end
		end
	end

	// Flags: a new event wins over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pm_q <= 1'b0;
			pw_q <= 1'b0;
			pr_q <= 1'b0;
		end else if (ce) begin
			pm_q <= (pm_q & ~(wr_stat & stat_w1c[STAT_PM])) | match_hit;
			pw_q <= (pw_q & ~(wr_stat & stat_w1c[STAT_PW])) | set_pw;
			pr_q <= (pr_q & ~(wr_stat & stat_w1c[STAT_PR])) | set_pr;
		end
	end

	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign run_active = go_q;
	assign period_match_flag = pm_q;
	assign width_capture_flag = pw_q;
	assign period_capture_flag = pr_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	property p_single_stop;
		ce && done && !repeat_q && !wr_ctrl |=> !go_q;
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("run not cleared");

	property p_repeat_run;
		ce && done && repeat_q && !wr_ctrl |=> go_q;
	endproperty
	a_repeat_run: assert property (p_repeat_run) else $error("repeat stopped");

	property p_timer_inc;
		ce && go_q && mode_q == MODE_TIMER && !match_hit && !sw_cnt
			|=> cnt_q == CNT_W'($past(cnt_q) + 1'b1);
	endproperty
	a_timer_inc: assert property (p_timer_inc) else $error("timer no increment");

	property p_match_wrap;
		ce && match_hit && !halt_q && !sw_cnt && !clr && !load1 |=> cnt_q == '0 && pm_q;
	endproperty
	a_match_wrap: assert property (p_match_wrap) else $error("match no wrap");

	property p_pd_load;
		ce && go_q && mode_q == MODE_PDUTY && sig_rise && !sw_cnt
			|=> cnt_q == LOAD_ONE[CNT_W-1:0] && cpr_q == $past(cnt_q);
	endproperty
	a_pd_load: assert property (p_pd_load) else $error("period load wrong");

	property p_pw_cap;
		ce && cap_pw |=> cpw_q == $past(cnt_q) && pw_q;
	endproperty
	a_pw_cap: assert property (p_pw_cap) else $error("width capture wrong");

	property p_halt;
		ce && match_hit && halt_q && !sw_cnt && !clr && !load1 |=> $stable(cnt_q);
	endproperty
	a_halt: assert property (p_halt) else $error("halt not held");

	property p_reserved;
		ce && mode_rsv && !sw_cnt && !cpw_req && !cpr_req
			|=> $stable(cnt_q) && $stable(cpw_q) && $stable(cpr_q);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved mode active");

	property p_sync;
		ce && $past(ce) && $past(ce, 2) |-> sig_s2_q == $past(measured_signal_input, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("sync depth wrong");

	c_match: cover property (ce && match_hit);
	c_tof_cpw: cover property (ce && mode_q == MODE_TOF && cap_pw);
	c_single_done: cover property (ce && done && !repeat_q);
endmodule

// *** testbench/source_model.sv ***
// Square-wave model of the on-chip signal and window sources
module source_model (
	// Clock and run control
	input wire logic ref_clk,
	input wire logic src_run,
	// Phase lengths in clock cycles
	input wire logic [7:0] sig_lo,
	input wire logic [7:0] sig_hi,
	input wire logic [7:0] win_lo,
	input wire logic [7:0] win_hi,
	// Source outputs
	output logic sig_pin,
	output logic win_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sig_cnt_q;
	logic [7:0] win_cnt_q;
	// Both waves restart low, so every edge time is known to the bench
	always_ff @(posedge ref_clk) begin
		if (!src_run) begin
			sig_pin <= 1'b0;
			win_pin <= 1'b0;
			sig_cnt_q <= 8'h01;
			win_cnt_q <= 8'h01;
		end else begin
			sig_cnt_q <= sig_cnt_q + 8'h01;
			win_cnt_q <= win_cnt_q + 8'h01;
			if (sig_cnt_q == (sig_pin ? sig_hi : sig_lo)) begin
				sig_pin <= ~sig_pin;
				sig_cnt_q <= 8'h01;
			end
			if (win_cnt_q == (win_pin ? win_hi : win_lo)) begin
				win_pin <= ~win_pin;
				win_cnt_q <= 8'h01;
			end
		end
	end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the signal measurement mode engine
module testbench
	import measure_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic ce = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o, q, a, b;
	logic ack_o, measured_signal_input, window_input, run_active;
	logic period_match_flag, width_capture_flag, period_capture_flag;
	logic src_run = 1'b0;
	logic [7:0] sig_lo = 8'h02;
	logic [7:0] sig_hi = 8'h06;
	logic [7:0] win_lo = 8'h20;
	logic [7:0] win_hi = 8'h20;
	logic [7:0] h, l;
	logic p;
	int bad_count = 0;
	int samples_checked = 0;

	always #12.5 ref_clk = ~ref_clk;

	signal_measurement_mode_engine i_signal_measurement_mode_engine (
		.ref_clk, .reset_n, .ce, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.measured_signal_input, .window_input, .run_active, .period_match_flag,
		.width_capture_flag, .period_capture_flag
	);

	source_model i_source_model (
		.ref_clk, .src_run, .sig_lo, .sig_hi, .win_lo, .win_hi,
		.sig_pin(measured_signal_input), .win_pin(window_input)
	);

	// ----------------------------------------
	// Tasks and expectation functions
	// ----------------------------------------
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic check_in(input string n, input logic [31:0] lo, hi, g);
		samples_checked++;
		if ($isunknown(g) || g < lo || g > hi) begin
			bad_count++;
			$display("[FAIL] %s expected %h..%h seen %h", n, lo, hi, g);
		end
	endtask
	task automatic lost(input string n);
		bad_count++;
		$display("[FAIL] %s expected done seen timeout", n);
		finish_test();
	endtask
	// Classic cycle: hold everything until ack is sampled, then release cyc and stb
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= ad;
		dat_i <= d;
		sel_i <= 4'hF;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (ack_o !== 1'b1) begin
			lost("bus ack");
		end
	endtask
	task automatic rd(input logic [7:0] ad);
		wb(1'b0, ad, 32'h0);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		wb(1'b1, ad, d);
	endtask
	function automatic logic [31:0] ctrl_word(input logic [3:0] m, input logic r,
		input logic [1:0] pl, input logic hl);
		ctrl_word = 32'h1 | (32'(r) << CTRL_REPEAT) | (32'(m) << CTRL_MODE_LSB)
			| (32'(hl) << CTRL_HALT) | (32'(pl) << CTRL_SIG_POL);
	endfunction
	// Active-low signal turns the measured width into the low phase
	function automatic logic [31:0] pw_exp(input logic [7:0] hi, lo, input logic pl);
		pw_exp = pl ? 32'(lo) : 32'(hi);
	endfunction
	function automatic logic flag(input int k);
		flag = (k == 0) ? width_capture_flag : (k == 1) ? period_capture_flag : !run_active;
	endfunction
	task automatic await(input int k);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (flag(k) !== 1'b1 && n < 3000);
		if (flag(k) !== 1'b1) begin
			lost("event wait");
		end
	endtask
	task automatic start(input logic [3:0] m, input logic r, input logic [1:0] pl);
		src_run <= 1'b0;
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_CNT, 32'h0);
		wr(ADDR_STAT, 32'h7);
		wr(ADDR_CTRL, ctrl_word(m, r, pl, 1'b0));
		src_run <= 1'b1;
	endtask
	// Flags are cleared first so the value read belongs to the next capture
	task automatic cap(input int k, output logic [31:0] v);
		wr(ADDR_STAT, 32'h7);
		await(k);
		rd(k == 1 ? ADDR_CPR : ADDR_CPW);
		v = q;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(32'h69F45067));
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(ADDR_CTRL);
		check("ctrl reset", 32'h0, q);
		rd(ADDR_LIMIT);
		check("limit reset", LIMIT_RST, q);
		rd(8'h20);
		check("unmapped read", 32'h0, q);
		wr(ADDR_LIMIT, 32'h9);
		start(MODE_TIMER, 1'b1, 2'b00);
		repeat (200) @(posedge ref_clk);
		rd(ADDR_CNT);
		check_in("timer wrap", 32'h0, 32'h9, q);
		check("match flag", 32'h1, 32'(period_match_flag));
		check("timer run", 32'h1, 32'(run_active));
		check("timer no capture", 32'h0, 32'({width_capture_flag, period_capture_flag}));
		wr(ADDR_CTRL, ctrl_word(MODE_TIMER, 1'b1, 2'b00, 1'b1));
		repeat (20) @(posedge ref_clk);
		rd(ADDR_CNT);
		check("halt hold", 32'h9, q);
		wr(ADDR_LIMIT, LIMIT_RST);
		start(MODE_GTIMER, 1'b1, 2'b00);
		cap(0, a);
		cap(0, a);
		cap(0, b);
		check("gated width step", 32'h6, b - a);
		start(MODE_HILO, 1'b1, 2'b00);
		cap(1, a);
		cap(0, a);
		cap(1, b);
		check("high minus low", 32'h4, a - b);
		start(MODE_CAPT, 1'b1, 2'b00);
		cap(1, a);
		cap(0, b);
		check("capture width", 32'h20, b - a);
		cap(1, b);
		check("capture period", 32'h40, b - a);
		start(MODE_WMEAS, 1'b1, 2'b00);
		cap(1, a);
		cap(1, a);
		check_in("window period", 32'h3F, 32'h40, a);
		start(MODE_GWMEAS, 1'b1, 2'b00);
		cap(1, a);
		cap(1, a);
		check_in("gated window", 32'h2F, 32'h31, a);
		start(MODE_CNTR, 1'b1, 2'b00);
		cap(0, a);
		cap(0, b);
		check("counter step", 32'h8, b - a);
		start(MODE_GCNTR, 1'b1, 2'b00);
		cap(0, a);
		cap(0, b);
		check("gated counter step", 32'h4, b - a);
		start(MODE_WCNTR, 1'b1, 2'b00);
		cap(1, a);
		cap(0, a);
		check("windowed width", 32'h4, a);
		cap(1, b);
		check("windowed period", 32'h8, b);
		sig_lo <= 8'h28;
		sig_hi <= 8'h18;
		start(MODE_TOF, 1'b1, 2'b00);
		cap(1, a);
		check_in("flight time", 32'h7, 32'h8, a);
		sig_lo <= 8'hFF;
		start(MODE_TOF, 1'b1, 2'b00);
		cap(0, a);
		check_in("flight no signal", 32'h3F, 32'h40, a);
		for (int m = 11; m < 16; m++) begin
			start(4'(m), 1'b1, 2'b00);
			repeat (100) @(posedge ref_clk);
			rd(ADDR_CNT);
			check("reserved count", 32'h0, q);
			check("reserved flags", 32'h0, 32'({period_match_flag, width_capture_flag,
				period_capture_flag}));
		end
		sig_hi <= 8'h05;
		sig_lo <= 8'h07;
		start(MODE_PDUTY, 1'b0, 2'b00);
		await(2);
		rd(ADDR_CPR);
		check("single period", 32'hC, q);
		rd(ADDR_CNT);
		a = q;
		repeat (30) @(posedge ref_clk);
		rd(ADDR_CNT);
		check("single stopped", a, q);
		wr(ADDR_STAT, 32'h7);
		wr(ADDR_CTRL, 32'h1 << CTRL_CPWUP);
		rd(ADDR_CPW);
		check("manual width update", a, q);
		check("manual width flag", 32'h1, 32'(width_capture_flag));
		wr(ADDR_CTRL, 32'h1 << CTRL_RST);
		rd(ADDR_CNT);
		check("manual counter reset", 32'h0, q);
		for (int i = 0; i < 4; i++) begin
			h = 8'(3 + $urandom % 12);
			l = 8'(3 + $urandom % 12);
			p = 1'($urandom % 2);
			sig_hi <= h;
			sig_lo <= l;
			start(MODE_PDUTY, 1'b1, {1'b0, p});
			cap(0, a);
			cap(0, a);
			check("duty width", pw_exp(h, l, p), a);
			cap(1, a);
			check("duty period", 32'(h) + 32'(l), a);
		end
		finish_test();
	end
endmodule
